// file: logic/prioc_pkg.sv
/*
  Constants for the programmable input and relay output logic: input and
  output function codes, register offsets and reset values.
  Assumes an AXI4-Lite slave with 32-bit data and byte addresses.
*/
package prioc_pkg;

  // Input function codes.
  localparam logic [3:0] IN_FREE = 4'h0;
  localparam logic [3:0] IN_ALT_PRESSURE = 4'h1;
  localparam logic [3:0] IN_SCHED_BYPASS = 4'h2;
  localparam logic [3:0] IN_LOAD_PERMIT = 4'h3;
  localparam logic [3:0] IN_REMOTE_LOAD = 4'h4;

  // Output function codes.
  localparam logic [3:0] OUT_FREE = 4'h0;
  localparam logic [3:0] OUT_OPERATING = 4'h1;
  localparam logic [3:0] OUT_ON_LOAD = 4'h2;
  localparam logic [3:0] OUT_OFF_LOAD = 4'h3;
  localparam logic [3:0] OUT_FAULT = 4'h4;
  localparam logic [3:0] OUT_WARNING = 4'h5;
  localparam logic [3:0] OUT_SERVICE = 4'h6;
  localparam logic [3:0] OUT_ALERT_SERVICE = 4'h7;
  localparam logic [3:0] OUT_ALL_CLEAR = 4'h8;
  localparam logic [3:0] OUT_FAR_START = 4'h9;
  localparam logic [3:0] OUT_RUNNING = 4'hA;

  // Register byte offsets.
  localparam logic [7:0] REG_IN_SEL = 8'h00;
  localparam logic [7:0] REG_OUT_SEL = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_CTRL = 8'h0C;

  // Field layout: four bits of function code per channel.
  localparam int SEL_W = 4;
  localparam int NUM_IN = 5;
  localparam int NUM_OUT = 2;

  // Reset values: output 1 carries the fault function, output 2 free.
  localparam logic [19:0] IN_SEL_RST = 20'h00000;
  localparam logic [7:0] OUT_SEL_RST = {OUT_FREE, OUT_FAULT};

  // Status bit positions.
  localparam int ST_ALT = 0;
  localparam int ST_BYPASS = 1;
  localparam int ST_REMOTE = 2;
  localparam int ST_LOAD = 3;
  localparam int ST_LINE_WARN = 4;
  localparam int ST_RELAY0 = 5;
  localparam int ST_RELAY1 = 6;
  localparam int ST_SCHED_OFF = 7;

  // Control bit: writing one acknowledges the line-pressure warning.
  localparam int CT_ACK = 0;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// file: logic/prioc_top.sv
/*
  Programmable input and relay output function logic for a compressor
  controller, with remote pressure changeover and remote load control.
  Five contact inputs each take one input function from a select field.
  Two relay drives each take one output function from a select field.
  The select fields, a status word and an acknowledge bit are reached
  over an AXI4-Lite slave with one read and up to two writes under way at most.
  Assumes contact inputs are asynchronous and pass two flip-flops here,
  and compressor status inputs come from logic on the same clock.
  Assumes the line overpressure compare is made outside and arrives here
  as a level; this block only latches it into the sticky warning.
  Assumes the compressor acts on START_REQUEST as a level, so holding the
  bypass contact closed keeps asking for a start while the timer is off.
  Assumes CE stays high during bus traffic: a handshake that the bus sees
  while CE is low is not taken, since all state, the bus too, is frozen.
*/
// Function
// - Five inputs, each takes any input function.
// - Closed alt-pressure contact selects second range.
// - Bypass contact overrides timer, starts stopped compressor.
// - Alt-pressure contact disables second-range timer schedule.
// - Two relay outputs: changeover and normally open.
// - Reset: output 1 fault, output 2 free.
// - Each output selects functions independently.
// - Unassigned output is never energized.
// - Operating: motor on or compressor ready.
// - On-load and off-load follow load state exactly.
// - Fault function energized only without faults.
// - Warning function energized only without warnings.
// - Service function energized only without maintenance.
// - Alert-service: no warning and no maintenance.
// - All-clear: no warning, maintenance or fault.
// - Far-start-ready: compressor ready for remote start.
// - Running: motor actually running.
// - Load permit: load set only remotely.
// - Remote load active means on-load, else off-load.
// - Overpressure warns, cancels remote until acknowledged.
`timescale 1ns/1ps
module prioc_top
  import prioc_pkg::*;
#(
  parameter int N_IN = NUM_IN,
  parameter int N_OUT = NUM_OUT
) (
  // Clock, reset and enable.
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic CE,
  // Contact inputs, high when closed.
  input wire logic [N_IN-1:0] CONTACT_IN,
  // Compressor status.
  input wire logic MOTOR_ON,
  input wire logic MOTOR_RUNNING,
  input wire logic READY,
  input wire logic FAR_START_READY,
  input wire logic FAULT_ACTIVE,
  input wire logic WARNING_ACTIVE,
  input wire logic SERVICE_DUE,
  input wire logic LOCAL_LOAD,
  input wire logic TIMER_STOPPED,
  input wire logic LINE_OVERPRESSURE,
  // Control outputs to the compressor.
  output logic ALT_PRESSURE_SELECT,
  output logic SCHEDULE_BYPASS,
  output logic ALT_SCHEDULE_DISABLE,
  output logic START_REQUEST,
  output logic LOAD_CMD,
  output logic REMOTE_ACTIVE,
  output logic LINE_PRESSURE_WARN,
  // Relay drives: output 1 changeover, output 2 normally open.
  output logic RELAY_OUT1,
  output logic RELAY_OUT2,
  // AXI4-Lite slave.
  input wire logic [7:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [7:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY
);

  ////////////////////////////////////////////////////////////////////////
  // State.

  // The whole state lives in one record so that CE can freeze it at once.
  typedef struct packed {
    // Two-stage synchroniser for the contact lines.
    logic [N_IN-1:0] sync1;
    logic [N_IN-1:0] sync2;
    // Function select fields, written by software.
    logic [19:0] in_sel;
    logic [7:0] out_sel;
    // Sticky line-pressure warning.
    logic line_warn;
    // Relay drives, registered so that a glitch never reaches a coil.
    logic [1:0] relay;
    // Control levels towards the compressor.
    logic alt;
    logic bypass;
    logic sched_off;
    logic start;
    logic load;
    logic remote;
    // Write channel holding registers.
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    // Read channel answer registers.
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } prioc_state_t;

  prioc_state_t s_q;
  prioc_state_t s_d;

  ////////////////////////////////////////////////////////////////////////
  // Output function decode, one function per output.

  function automatic logic prioc_drive(input logic [3:0] sel,
                                       input logic load_now);
    logic r;
    r = 1'b0;
    unique case (sel)
      OUT_FREE: r = 1'b0;
      OUT_OPERATING: r = MOTOR_ON | READY;
      OUT_ON_LOAD: r = load_now;
      OUT_OFF_LOAD: r = ~load_now;
      OUT_FAULT: r = ~FAULT_ACTIVE;
      OUT_WARNING: r = ~WARNING_ACTIVE;
      OUT_SERVICE: r = ~SERVICE_DUE;
      OUT_ALERT_SERVICE: r = ~(WARNING_ACTIVE | SERVICE_DUE);
      OUT_ALL_CLEAR: begin
        r = ~(WARNING_ACTIVE | SERVICE_DUE | FAULT_ACTIVE);
      end
      OUT_FAR_START: r = FAR_START_READY;
      OUT_RUNNING: r = MOTOR_RUNNING;
      // Codes above the list are treated as unassigned.
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // Merged write data under byte strobes.
  function automatic logic [31:0] prioc_merge(input logic [31:0] old,
                                              input logic [31:0] nw,
                                              input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        m[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  always_comb begin
    logic [31:0] merged;
    logic [3:0] fsel;
    logic any_alt;
    logic any_byp;
    logic any_permit;
    logic any_rload;
    logic ack;
    logic load_now;
    merged = 32'h0000_0000;
    fsel = 4'h0;
    any_alt = 1'b0;
    any_byp = 1'b0;
    any_permit = 1'b0;
    any_rload = 1'b0;
    ack = 1'b0;
    s_d = s_q;
    // Contacts cross in through two flip-flops.
    s_d.sync1 = CONTACT_IN;
    s_d.sync2 = s_q.sync1;

    // Each input ORs into the function it is assigned.
    // Two inputs given one function act as a wired OR of their contacts,
    // so a spare terminal can be paralleled without software help.
    // Only synchronised contacts are read; the first stage never is.
    for (int i = 0; i < N_IN; i++) begin
      fsel = s_q.in_sel[i*SEL_W +: SEL_W];
      if (s_q.sync2[i]) begin
        any_alt = any_alt | (fsel == IN_ALT_PRESSURE);
        any_byp = any_byp | (fsel == IN_SCHED_BYPASS);
        any_permit = any_permit | (fsel == IN_LOAD_PERMIT);
        any_rload = any_rload | (fsel == IN_REMOTE_LOAD);
      end
    end

    // Write channel: take address and data in either order.
    // Each half is held until both are present; the write then executes
    // in one cycle and the readies rise again only after that, so a
    // second write cannot overtake a response still being returned.
    if (AWVALID && !s_q.aw_have) begin
      s_d.aw_have = 1'b1;
      s_d.aw_addr = AWADDR;
    end
    if (WVALID && !s_q.w_have) begin
      s_d.w_have = 1'b1;
      s_d.w_data = WDATA;
      s_d.w_strb = WSTRB;
    end
    if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
      s_d.aw_have = 1'b0;
      s_d.w_have = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = RESP_OKAY;
      unique case (s_q.aw_addr)
        REG_IN_SEL: begin
          merged = prioc_merge({12'h000, s_q.in_sel}, s_q.w_data,
                               s_q.w_strb);
          s_d.in_sel = merged[19:0];
        end
        REG_OUT_SEL: begin
          merged = prioc_merge({24'h000000, s_q.out_sel}, s_q.w_data,
                               s_q.w_strb);
          s_d.out_sel = merged[7:0];
        end
        REG_CTRL: begin
          // Only a one in bit zero under its strobe acknowledges.
          ack = s_q.w_strb[0] & s_q.w_data[CT_ACK];
        end
        REG_STATUS: begin
          // Status is read-only; the write is answered and dropped.
          ack = 1'b0;
        end
        default: s_d.bresp = RESP_SLVERR;
      endcase
    end
    if (s_q.bvalid && BREADY) begin
      s_d.bvalid = 1'b0;
    end

    // Read channel: answer one cycle after the address is taken.
    // The data register is loaded only when no answer stands, so the
    // word that the master sees cannot change under a stalled RREADY.
    if (ARVALID && !s_q.rvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = RESP_OKAY;
      unique case (ARADDR)
        REG_IN_SEL: s_d.rdata = {12'h000, s_q.in_sel};
        REG_OUT_SEL: s_d.rdata = {24'h000000, s_q.out_sel};
        REG_STATUS: begin
          s_d.rdata = 32'h0000_0000;
          s_d.rdata[ST_ALT] = s_q.alt;
          s_d.rdata[ST_BYPASS] = s_q.bypass;
          s_d.rdata[ST_REMOTE] = s_q.remote;
          s_d.rdata[ST_LOAD] = s_q.load;
          s_d.rdata[ST_LINE_WARN] = s_q.line_warn;
          s_d.rdata[ST_RELAY0] = s_q.relay[0];
          s_d.rdata[ST_RELAY1] = s_q.relay[1];
          s_d.rdata[ST_SCHED_OFF] = s_q.sched_off;
        end
        REG_CTRL: s_d.rdata = 32'h0000_0000;
        default: begin
          s_d.rdata = 32'h0000_0000;
          s_d.rresp = RESP_SLVERR;
        end
      endcase
    end else if (s_q.rvalid && RREADY) begin
      s_d.rvalid = 1'b0;
    end

    // Overpressure sets the warning; it wins over the acknowledge.
    // An acknowledge while the pressure is still high would otherwise
    // hand load control back to the remote contacts too early.
    if (LINE_OVERPRESSURE) begin
      s_d.line_warn = 1'b1;
    end else if (ack) begin
      s_d.line_warn = 1'b0;
    end

    // Pressure range and timer handling from the contacts.
    s_d.alt = any_alt;
    s_d.sched_off = any_alt;
    s_d.bypass = any_byp;
    s_d.start = any_byp & TIMER_STOPPED;

    // Remote load control holds only while no line warning stands.
    // The next warning value is used, so remote control drops in the
    // same cycle as the warning rises and never lags it by one edge.
    s_d.remote = any_permit & ~s_d.line_warn;
    load_now = s_d.remote ? any_rload : LOCAL_LOAD;
    s_d.load = load_now;

    // Relays follow status every cycle.
    // Load-based functions use the same load value as LOAD_CMD, so the
    // on-load relay and the load command always change on one edge.
    for (int o = 0; o < N_OUT; o++) begin
      s_d.relay[o] = prioc_drive(s_q.out_sel[o*SEL_W +: SEL_W],
                                 load_now);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register; CE low freezes everything.
  // Reset loads only constants: select fields take their delivery values,
  // and all relays are off until the first edge after release.

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      s_q <= '0;
      s_q.in_sel <= IN_SEL_RST;
      s_q.out_sel <= OUT_SEL_RST;
    end else if (CE) begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs.
  // All data outputs come straight from flip-flops; only the readies are
  // decoded, and those from registered flags alone.

  assign ALT_PRESSURE_SELECT = s_q.alt;
  assign SCHEDULE_BYPASS = s_q.bypass;
  assign ALT_SCHEDULE_DISABLE = s_q.sched_off;
  assign START_REQUEST = s_q.start;
  assign LOAD_CMD = s_q.load;
  assign REMOTE_ACTIVE = s_q.remote;
  assign LINE_PRESSURE_WARN = s_q.line_warn;
  // Relay 1 drives the changeover coil, relay 2 the NO coil.
  assign RELAY_OUT1 = s_q.relay[0];
  assign RELAY_OUT2 = s_q.relay[1];
  // Ready while nothing is held; a held pair waits for the response.
  assign AWREADY = ~s_q.aw_have;
  assign WREADY = ~s_q.w_have;
  assign BVALID = s_q.bvalid;
  assign BRESP = s_q.bresp;
  assign ARREADY = ~s_q.rvalid;
  assign RVALID = s_q.rvalid;
  assign RRESP = s_q.rresp;
  assign RDATA = s_q.rdata;

endmodule

// file: bench/prioc_chk.sv
/*
  Port checker for prioc_top, bound to every instance.
  Assumes CE is held high, so every edge advances the state.
*/
`timescale 1ns/1ps
module prioc_chk (
  // Clock and reset.
  input wire logic CLK,
  input wire logic RESET_N,
  // Compressor side.
  input wire logic ALT_PRESSURE_SELECT, ALT_SCHEDULE_DISABLE,
  input wire logic SCHEDULE_BYPASS, START_REQUEST, TIMER_STOPPED,
  input wire logic LOAD_CMD, LOCAL_LOAD, REMOTE_ACTIVE,
  input wire logic LINE_PRESSURE_WARN, LINE_OVERPRESSURE,
  // Register bus.
  input wire logic AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY,
  input wire logic ARVALID, ARREADY, RVALID, RREADY,
  input wire logic [1:0] BRESP,
  input wire logic [31:0] RDATA
);
  // All checks share the one clock and the one reset.
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  alt_sched_a: assert property (
    ALT_PRESSURE_SELECT == ALT_SCHEDULE_DISABLE)
    else $error("alt range and schedule disable differ");
  start_req_a: assert property (
    START_REQUEST |-> SCHEDULE_BYPASS && $past(TIMER_STOPPED))
    else $error("start request without cause");
  local_load_a: assert property (
    $past(RESET_N) && !REMOTE_ACTIVE && !$past(REMOTE_ACTIVE)
    |-> LOAD_CMD == $past(LOCAL_LOAD))
    else $error("load not from ranges while local");
  warn_set_a: assert property (
    $past(RESET_N) && $past(LINE_OVERPRESSURE) |-> LINE_PRESSURE_WARN)
    else $error("line warning not raised");
  warn_remote_a: assert property (
    LINE_PRESSURE_WARN |-> !REMOTE_ACTIVE)
    else $error("remote load kept during line warning");
  bresp_hold_a: assert property (
    BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response dropped");
  rdata_hold_a: assert property (
    RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read data dropped");
  read_answer_a: assert property (
    ARVALID && ARREADY |=> RVALID)
    else $error("read not answered");
  write_answer_a: assert property (
    AWVALID && AWREADY && WVALID && WREADY |-> ##[1:2] BVALID)
    else $error("write not answered");

  // Main scenarios reached.
  cover property (LINE_PRESSURE_WARN && !LINE_OVERPRESSURE);
  cover property (START_REQUEST);
  cover property (REMOTE_ACTIVE && LOAD_CMD);
endmodule

bind prioc_top prioc_chk i_prioc_chk (.*);

// file: bench/prioc_far.sv
/*
  Model of the five potential-free contacts outside the block.
  Assumes the bench sets the wanted positions; closed reads as one.
*/
`timescale 1ns/1ps
module prioc_far (
  // Wanted contact positions.
  input wire logic [4:0] want,
  // Contact lines at the terminals.
  output logic [4:0] contact
);
  // Contacts move off the clock grid, so the synchroniser is exercised;
  // the remote load contact is one of them.
  initial contact = 5'h00;
  always @(want) contact <= #3 want;
endmodule

// file: bench/prioc_tb_top.sv
/*
  Self-checking bench for prioc_top: relays, remote load, changeover, bus.
  Assumes prioc_far drives the contacts and prioc_chk is bound.
*/
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin fail_count++; \
  $display("CHECK FAILED %s expected %0h seen %0h", n, e, a); end end
module prioc_tb_top
  import prioc_pkg::*;
;
  logic CLK = 1'b0, RESET_N = 1'b0, CE = 1'b1;
  logic [9:0] st = 10'h000;
  logic [4:0] want = 5'h00, contact;
  wire logic MOTOR_ON, MOTOR_RUNNING, READY, FAR_START_READY, FAULT_ACTIVE,
    WARNING_ACTIVE, SERVICE_DUE, LOCAL_LOAD, TIMER_STOPPED, LINE_OVERPRESSURE;
  logic ALT_PRESSURE_SELECT, SCHEDULE_BYPASS, ALT_SCHEDULE_DISABLE,
    START_REQUEST, LOAD_CMD, REMOTE_ACTIVE, LINE_PRESSURE_WARN, RELAY_OUT1,
    RELAY_OUT2, AWREADY, WREADY, BVALID, ARREADY, RVALID;
  logic [1:0] BRESP, RRESP, r;
  logic [31:0] RDATA, d, WDATA = 32'h0;
  logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00;
  logic [3:0] WSTRB = 4'hF;
  logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0;
  logic ARVALID = 1'b0, RREADY = 1'b0;
  int checks = 0, fail_count = 0, cyc = 0;

  // Status vector drives the compressor inputs.
  assign {LINE_OVERPRESSURE, TIMER_STOPPED, LOCAL_LOAD, SERVICE_DUE,
    WARNING_ACTIVE, FAULT_ACTIVE, FAR_START_READY, READY, MOTOR_RUNNING,
    MOTOR_ON} = st;
  prioc_top i_prioc_top (.CONTACT_IN(contact), .*);
  prioc_far i_prioc_far (.want(want), .contact(contact));

  // Clock and a hang limit well above the run length.
  always #5 CLK = ~CLK;
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      close_out();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Let n edges pass, then look where outputs have settled.
  task automatic w(int n);
    repeat (n) @(posedge CLK);
    @(negedge CLK);
  endtask

  // Write: readies sampled mid-cycle are what the next edge acts on.
  task automatic wr(logic [7:0] a, logic [31:0] v, output logic [1:0] rs);
    logic aw, wd, bv;
    @(posedge CLK);
    AWADDR <= a; WDATA <= v; AWVALID <= 1'b1; WVALID <= 1'b1; BREADY <= 1'b1;
    do begin
      @(negedge CLK);
      aw = AWREADY; wd = WREADY; bv = BVALID; rs = BRESP;
      @(posedge CLK);
      if (aw) AWVALID <= 1'b0;
      if (wd) WVALID <= 1'b0;
    end while (!bv);
    BREADY <= 1'b0;
  endtask

  task automatic rd(logic [7:0] a, output logic [31:0] v,
                    output logic [1:0] rs);
    logic ar, rv;
    @(posedge CLK);
    ARADDR <= a; ARVALID <= 1'b1; RREADY <= 1'b1;
    do begin
      @(negedge CLK);
      ar = ARREADY; rv = RVALID; v = RDATA; rs = RRESP;
      @(posedge CLK);
      if (ar) ARVALID <= 1'b0;
    end while (!rv);
    RREADY <= 1'b0;
  endtask

  // Relay level expected for a function code and a status vector.
  function automatic logic exp_rel(logic [3:0] c, logic [9:0] s);
    case (c)
      OUT_OPERATING: return s[0] | s[2];
      OUT_ON_LOAD: return s[7];
      OUT_OFF_LOAD: return !s[7];
      OUT_FAULT: return !s[4];
      OUT_WARNING: return !s[5];
      OUT_SERVICE: return !s[6];
      OUT_ALERT_SERVICE: return !(s[5] | s[6]);
      OUT_ALL_CLEAR: return !(s[4] | s[5] | s[6]);
      OUT_FAR_START: return s[3];
      OUT_RUNNING: return s[1];
      default: return 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd(REG_OUT_SEL, d, r);
    `CHK("out_sel", {24'h0, OUT_FREE, OUT_FAULT}, d)
    rd(REG_IN_SEL, d, r);
    `CHK("in_sel", 32'h0, d)
    w(1);
    `CHK("relay1", 1'b1, RELAY_OUT1)
    `CHK("relay2", 1'b0, RELAY_OUT2)
    $display("reset test done");
  endtask

  task automatic t_bus;
    rd(8'h10, d, r);
    `CHK("rresp", RESP_SLVERR, r)
    `CHK("rdata", 32'h0, d)
    wr(8'h10, 32'hFFFFFFFF, r);
    `CHK("bresp", RESP_SLVERR, r)
    wr(REG_STATUS, 32'hFFFFFFFF, r);
    `CHK("bresp", RESP_OKAY, r)
    rd(REG_OUT_SEL, d, r);
    `CHK("out_sel", 32'h04, d)
    $display("bus test done");
  endtask

  // Every code on output 2 against a different code on output 1.
  task automatic t_relays;
    logic [9:0] s;
    for (int c = 0; c < 16; c++) begin
      wr(REG_OUT_SEL, {24'h0, 4'(c), 4'(15 - c)}, r);
      for (int p = 0; p < 9; p++) begin
        s = (p < 8) ? 10'(1 << p) : 10'h000;
        @(posedge CLK);
        st <= s;
        w(2);
        `CHK("relay1", exp_rel(4'(15 - c), s), RELAY_OUT1)
        `CHK("relay2", exp_rel(4'(c), s), RELAY_OUT2)
      end
    end
    $display("relay test done");
  endtask

  // Inputs: 0 permit, 1 remote load, 2 alt range, 3 bypass.
  task automatic t_remote;
    wr(REG_IN_SEL, {12'h0, IN_FREE, IN_SCHED_BYPASS, IN_ALT_PRESSURE,
       IN_REMOTE_LOAD, IN_LOAD_PERMIT}, r);
    st <= 10'h180;
    want <= 5'h01;
    w(6);
    `CHK("remote", 1'b1, REMOTE_ACTIVE)
    `CHK("load", 1'b0, LOAD_CMD)
    @(posedge CLK);
    st <= 10'h100;
    want <= 5'h0F;
    w(6);
    `CHK("load", 1'b1, LOAD_CMD)
    `CHK("alt", 1'b1, ALT_PRESSURE_SELECT)
    `CHK("sched_off", 1'b1, ALT_SCHEDULE_DISABLE)
    `CHK("bypass", 1'b1, SCHEDULE_BYPASS)
    `CHK("start", 1'b1, START_REQUEST)
    @(posedge CLK);
    st <= 10'h300;
    @(posedge CLK);
    st <= 10'h100;
    w(2);
    `CHK("remote", 1'b0, REMOTE_ACTIVE)
    `CHK("load", 1'b0, LOAD_CMD)
    rd(REG_STATUS, d, r);
    `CHK("status", 8'h93, d[7:0])
    wr(REG_CTRL, 32'h1, r);
    w(3);
    `CHK("warn", 1'b0, LINE_PRESSURE_WARN)
    `CHK("load", 1'b1, LOAD_CMD)
    $display("remote test done");
  endtask

  initial begin
    repeat (10) @(posedge CLK);
    RESET_N <= 1'b1;
    t_reset();
    t_bus();
    t_relays();
    t_remote();
    close_out();
  end
endmodule
